// ### hw/tile_pkg.sv
// Purpose: shared constants for the configurable logic tile
// Assumes: registers sit at word-aligned byte addresses on a 5-bit bus
// Notes:   field positions below index into the config registers
// ============================================================
// Notes on behaviour
// - each cell has lookup table, carry, storage
// - table output feeds tile output and storage
// - four cells in two identical slices
// - table may act as 16x1 synchronous RAM
// - slice tables combine: 16x2, 32x1, dual-port
// - table may act as 16-stage shift register
// - storage element is flip-flop or latch
// - storage data from table or direct input
// - init force loads configured initial state
// - inverse force loads complement of initial state
// - forces synchronous by default, optionally asynchronous
// - slice clock, enable and forces invertible and shared per slice
// - pair mux selects between slice table outputs
// - quad mux selects between pair mux outputs
// - one direct feedthrough path per cell
// - separate two-bit carry chain per slice
// - xor full adder plus multiplier and gate
// - carry path cascades tables into wide logic
// - two tristate drivers, own data and enable
package tile_pkg;
  // ============================================================
  // sizes
  localparam int NUM_SLICES = 2;
  localparam int CELLS_PER_SLICE = 2;
  localparam int NUM_CELLS = 4;
  localparam int LUT_INPUTS = 4;
  localparam int LUT_DEPTH = 16;
  localparam int CELL_FIELD_W = 8;
  localparam int SLICE_FIELD_W = 8;
  // ============================================================
  // register byte addresses
  localparam logic [4:0] TABLE_BASE = 5'h00;  // four tables, one word each
  localparam logic [4:0] CELL_CFG_ADDR = 5'h10;
  localparam logic [4:0] SLICE_CFG_ADDR = 5'h14;
  localparam logic [4:0] STATUS_ADDR = 5'h18;
  // ============================================================
  // per-cell config field positions
  localparam int MODE_LSB = 0;    // two bits, lut_mode_t
  localparam int LATCH_BIT = 2;   // 1 = latch, 0 = flip-flop
  localparam int BYPASS_BIT = 3;  // 1 = direct input feeds storage
  localparam int INIT_BIT = 4;    // configured initial state
  localparam int GEN_LSB = 5;     // two bits, gen_t
  // per-slice config field positions
  localparam int COMBINE_LSB = 0; // two bits, combine_t
  localparam int ASYNC_BIT = 2;
  localparam int CLK_INV_BIT = 3;
  localparam int CE_INV_BIT = 4;
  localparam int INIT_INV_BIT = 5;
  localparam int INVERSE_INV_BIT = 6;
  // ============================================================
  // reset values
  localparam logic [15:0] TABLE_RESET = 16'h0000;
  localparam logic [31:0] CELL_CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] SLICE_CFG_RESET = 16'h0000;
  // ============================================================
  // modes
  typedef enum logic [1:0] {
    LUT_LOGIC = 2'b00, LUT_RAM = 2'b01, LUT_SHIFT = 2'b10
  } lut_mode_t;
  typedef enum logic [1:0] {
    COMB_SEPARATE = 2'b00, COMB_16X2 = 2'b01, COMB_32X1 = 2'b10, COMB_DUAL = 2'b11
  } combine_t;
  typedef enum logic [1:0] {
    GEN_OPERAND = 2'b00, GEN_AND = 2'b01, GEN_CASCADE = 2'b10
  } gen_t;
endpackage

// ### hw/logic_tile.sv
// Purpose: one configurable logic tile of four cells in two slices
// Assumes: fabric inputs share CLOCK; slice clocks are sampled levels
// Notes:   lookup, mux, carry and bus outputs are combinational paths
`timescale 1ns/1ns
module logic_tile (
  // system
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // register port
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // per-cell fabric inputs
  input  wire logic [15:0] CELL_IN,
  input  wire logic [3:0]  DIRECT_IN,
  input  wire logic [3:0]  FEED_IN,
  // per-slice and tile controls
  input  wire logic [1:0]  SLICE_CLK,
  input  wire logic [1:0]  SLICE_CE,
  input  wire logic [1:0]  INIT_FORCE,
  input  wire logic [1:0]  INVERSE_FORCE,
  input  wire logic [1:0]  WRITE_EN,
  input  wire logic [1:0]  PAIR_SEL,
  input  wire logic        QUAD_SEL,
  input  wire logic [1:0]  CARRY_IN,
  // tristate driver inputs
  input  wire logic [1:0]  TBUF_IN,
  input  wire logic [1:0]  TBUF_EN,
  // per-cell outputs
  output logic      [3:0]  LUT_OUT,
  output logic      [3:0]  STORE_OUT,
  output logic      [3:0]  SUM_OUT,
  output logic      [3:0]  PRODUCT_OUT,
  output logic      [3:0]  FEED_OUT,
  // per-slice and tile outputs
  output logic      [1:0]  PAIR_OUT,
  output logic             QUAD_OUT,
  output logic      [1:0]  CARRY_OUT,
  // tristate bus pins
  output logic      [1:0]  TBUS_OUT,
  output logic      [1:0]  TBUS_OE
);
  // ============================================================
  // configuration state
  logic [15:0] table_q [tile_pkg::NUM_CELLS];  // truth table or ram/shift bits
  logic [31:0] cell_cfg;                       // one byte per cell
  logic [15:0] slice_cfg;                      // one byte per slice
  logic [3:0]  store_q;                        // storage elements

  // slice clock sampling: sync pair plus history
  logic [1:0] clk_meta;                        // first stage, read only by clk_sync
  logic [1:0] clk_sync;
  logic [1:0] clk_prev;

  // decoded per-slice controls after polarity option
  logic [1:0] clk_level;
  logic [1:0] clk_edge;
  logic [1:0] ce_act;
  logic [1:0] init_act;
  logic [1:0] inverse_act;
  logic [1:0] async_mode;
  logic [1:0] combine [tile_pkg::NUM_SLICES];

  // decoded per-cell fields
  logic [1:0] mode   [tile_pkg::NUM_CELLS];
  logic [3:0] rd_addr [tile_pkg::NUM_CELLS];
  logic [3:0] wr_addr [tile_pkg::NUM_CELLS];
  logic [3:0] wr_data;
  logic [3:0] ram_we;
  logic [3:0] lut_val;
  logic [3:0] store_d;

  // ============================================================
  // slice control decode
  always_comb begin
    for (int s = 0; s < tile_pkg::NUM_SLICES; s++) begin
      async_mode[s]  = slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::ASYNC_BIT];
      combine[s]     = slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::COMBINE_LSB +: 2];
      // each control gets its own inversion bit, shared by both cells
      clk_level[s]   = clk_sync[s] ^
                       slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::CLK_INV_BIT];
      clk_edge[s]    = clk_level[s] &
                       ~(clk_prev[s] ^
                         slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::CLK_INV_BIT]);
      ce_act[s]      = SLICE_CE[s] ^
                       slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::CE_INV_BIT];
      init_act[s]    = INIT_FORCE[s] ^
                       slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::INIT_INV_BIT];
      inverse_act[s] = INVERSE_FORCE[s] ^
                       slice_cfg[s*tile_pkg::SLICE_FIELD_W + tile_pkg::INVERSE_INV_BIT];
    end
  end

  // ============================================================
  // slice clock synchroniser; edges seen on the second stage only
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_meta <= 2'h0;
      clk_sync <= 2'h0;
      clk_prev <= 2'h0;
    end else begin
      clk_meta <= SLICE_CLK;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // ============================================================
  // table addressing for the ram combinations
  always_comb begin
    for (int c = 0; c < tile_pkg::NUM_CELLS; c++) begin
      int s;
      int e;
      s = c / tile_pkg::CELLS_PER_SLICE;
      e = s * tile_pkg::CELLS_PER_SLICE;   // even cell of the slice
      mode[c]    = cell_cfg[c*tile_pkg::CELL_FIELD_W + tile_pkg::MODE_LSB +: 2];
      rd_addr[c] = CELL_IN[c*tile_pkg::LUT_INPUTS +: 4];
      wr_addr[c] = CELL_IN[c*tile_pkg::LUT_INPUTS +: 4];
      wr_data[c] = DIRECT_IN[c];
      ram_we[c]  = WRITE_EN[s] && (mode[c] == tile_pkg::LUT_RAM);
      if (c != e && mode[c] == tile_pkg::LUT_RAM) begin
        if (combine[s] == tile_pkg::COMB_16X2) begin
          // both bits share one address, each its own data
          rd_addr[c] = CELL_IN[e*tile_pkg::LUT_INPUTS +: 4];
          wr_addr[c] = CELL_IN[e*tile_pkg::LUT_INPUTS +: 4];
        end else if (combine[s] == tile_pkg::COMB_DUAL) begin
          // odd table mirrors writes, read address stays its own
          wr_addr[c] = CELL_IN[e*tile_pkg::LUT_INPUTS +: 4];
          wr_data[c] = DIRECT_IN[e];
        end else if (combine[s] == tile_pkg::COMB_32X1) begin
          // odd table is the upper half of one 32-deep word, same address both ways
          rd_addr[c] = CELL_IN[e*tile_pkg::LUT_INPUTS +: 4];
          wr_addr[c] = CELL_IN[e*tile_pkg::LUT_INPUTS +: 4];
          wr_data[c] = DIRECT_IN[e];
        end
      end
      // in 32x1 the pair select is the fifth address bit
      if (mode[c] == tile_pkg::LUT_RAM && combine[s] == tile_pkg::COMB_32X1) begin
        ram_we[c] = WRITE_EN[s] && (PAIR_SEL[s] == (c != e));
      end
    end
  end

  // ============================================================
  // table contents: bus load, ram write or shift
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int c = 0; c < tile_pkg::NUM_CELLS; c++) begin
        table_q[c] <= tile_pkg::TABLE_RESET;
      end
    end else begin
      for (int c = 0; c < tile_pkg::NUM_CELLS; c++) begin
        if (REG_WR && REG_ADDR == tile_pkg::TABLE_BASE + 5'(c*4)) begin
          // a bus load beats fabric activity in the same cycle
          table_q[c] <= REG_WDATA[15:0];
        end else if (clk_edge[c/2] && ram_we[c]) begin
          table_q[c][wr_addr[c]] <= wr_data[c];
        end else if (clk_edge[c/2] && ce_act[c/2] && mode[c] == tile_pkg::LUT_SHIFT) begin
          table_q[c] <= {table_q[c][14:0], DIRECT_IN[c]};
        end
      end
    end
  end

  // ============================================================
  // lookup read: logic, ram read and shift tap all index the table
  always_comb begin
    for (int c = 0; c < tile_pkg::NUM_CELLS; c++) begin
      lut_val[c] = table_q[c][rd_addr[c]];
      // storage takes the table output unless bypass is chosen
      store_d[c] = cell_cfg[c*tile_pkg::CELL_FIELD_W + tile_pkg::BYPASS_BIT] ?
                   DIRECT_IN[c] : lut_val[c];
    end
  end

  assign LUT_OUT = lut_val;

  // ============================================================
  // storage elements: flip-flop or latch with forces
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      store_q <= 4'h0;
    end else begin
      for (int c = 0; c < tile_pkg::NUM_CELLS; c++) begin
        logic init_v;
        logic latch_v;
        init_v  = cell_cfg[c*tile_pkg::CELL_FIELD_W + tile_pkg::INIT_BIT];
        latch_v = cell_cfg[c*tile_pkg::CELL_FIELD_W + tile_pkg::LATCH_BIT];
        if (async_mode[c/2] && init_act[c/2]) begin
          store_q[c] <= init_v;
        end else if (async_mode[c/2] && inverse_act[c/2]) begin
          store_q[c] <= ~init_v;
        end else if (latch_v ? clk_level[c/2] : clk_edge[c/2]) begin
          // latch is open while the level is active, ff acts on the edge
          if (!async_mode[c/2] && init_act[c/2]) begin
            store_q[c] <= init_v;
          end else if (!async_mode[c/2] && inverse_act[c/2]) begin
            store_q[c] <= ~init_v;
          end else if (ce_act[c/2]) begin
            store_q[c] <= store_d[c];
          end
        end
      end
    end
  end

  assign STORE_OUT = store_q;

  // ============================================================
  // wide function muxes
  always_comb begin
    for (int s = 0; s < tile_pkg::NUM_SLICES; s++) begin
      // select picks the odd table when high
      PAIR_OUT[s] = PAIR_SEL[s] ? lut_val[2*s+1] : lut_val[2*s];
    end
  end

  assign QUAD_OUT = QUAD_SEL ? PAIR_OUT[1] : PAIR_OUT[0];

  // ============================================================
  // carry chains, one per slice, two bits each
  always_comb begin
    for (int s = 0; s < tile_pkg::NUM_SLICES; s++) begin
      logic cy;
      cy = CARRY_IN[s];  // chains never cross slices
      for (int k = 0; k < tile_pkg::CELLS_PER_SLICE; k++) begin
        int c;
        logic gen;
        gen = 1'b0;
        c = s * tile_pkg::CELLS_PER_SLICE + k;
        PRODUCT_OUT[c] = CELL_IN[c*4] & CELL_IN[c*4+1];
        SUM_OUT[c] = lut_val[c] ^ cy;
        case (cell_cfg[c*tile_pkg::CELL_FIELD_W + tile_pkg::GEN_LSB +: 2])
          tile_pkg::GEN_AND: gen = PRODUCT_OUT[c];
          // zero generate turns the chain into a wide and
          tile_pkg::GEN_CASCADE: gen = 1'b0;
          default: gen = CELL_IN[c*4];
        endcase
        // propagate when the table says so, else generate
        cy = lut_val[c] ? cy : gen;
      end
      CARRY_OUT[s] = cy;
    end
  end

  // ============================================================
  // feedthrough and tristate drivers
  assign FEED_OUT = FEED_IN;
  // data and enable are independent per driver
  assign TBUS_OUT = TBUF_IN;
  assign TBUS_OE  = TBUF_EN;

  // ============================================================
  // config register writes
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cell_cfg <= tile_pkg::CELL_CFG_RESET;
    end else if (REG_WR && REG_ADDR == tile_pkg::CELL_CFG_ADDR) begin
      cell_cfg <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      slice_cfg <= tile_pkg::SLICE_CFG_RESET;
    end else if (REG_WR && REG_ADDR == tile_pkg::SLICE_CFG_ADDR) begin
      slice_cfg <= REG_WDATA[15:0];
    end
  end

  // ============================================================
  // register read, answered one cycle later; unmapped reads zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (!REG_RD) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_ADDR < tile_pkg::CELL_CFG_ADDR && REG_ADDR[1:0] == 2'h0) begin
      REG_RDATA <= {16'h0000, table_q[REG_ADDR[3:2]]};
    end else if (REG_ADDR == tile_pkg::CELL_CFG_ADDR) begin
      REG_RDATA <= cell_cfg;
    end else if (REG_ADDR == tile_pkg::SLICE_CFG_ADDR) begin
      REG_RDATA <= {16'h0000, slice_cfg};
    end else if (REG_ADDR == tile_pkg::STATUS_ADDR) begin
      // live tile state: storage, table outputs, muxes, carries
      REG_RDATA <= {19'h00000, CARRY_OUT, QUAD_OUT, PAIR_OUT, lut_val, store_q};
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

endmodule

// ### verification/tile_sva.sv
// Purpose: port-level checks for the logic tile
// Assumes: attached by bind, single CLOCK domain
// Notes:   combinational paths are sampled at each CLOCK edge
`timescale 1ns/1ns
module tile_sva (
  // system
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  // register port
  input wire logic [4:0]  REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // fabric
  input wire logic [15:0] CELL_IN,
  input wire logic [3:0]  FEED_IN,
  input wire logic [3:0]  FEED_OUT,
  input wire logic [3:0]  LUT_OUT,
  input wire logic [3:0]  PRODUCT_OUT,
  input wire logic [1:0]  PAIR_SEL,
  input wire logic [1:0]  PAIR_OUT,
  input wire logic        QUAD_SEL,
  input wire logic        QUAD_OUT,
  // tristate drivers
  input wire logic [1:0]  TBUF_IN,
  input wire logic [1:0]  TBUF_EN,
  input wire logic [1:0]  TBUS_OUT,
  input wire logic [1:0]  TBUS_OE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  // ============================================================
  // read strobes, answered one cycle later
  sequence status_rd;
    REG_RD && REG_ADDR == tile_pkg::STATUS_ADDR;
  endsequence
  sequence table_rd;
    REG_RD && REG_ADDR < tile_pkg::CELL_CFG_ADDR;
  endsequence
  // ============================================================
  // register port
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  status_lut_a: assert property (status_rd |=>
    REG_RDATA[31:13] == 19'h00000 && REG_RDATA[7:4] == $past(LUT_OUT))
    else $error("status read does not show table outputs");
  table_width_a: assert property (table_rd |=> REG_RDATA[31:16] == 16'h0000)
    else $error("table read upper half not zero");
  // ============================================================
  // combinational fabric paths
  feed_through_a: assert property (FEED_OUT == FEED_IN)
    else $error("feedthrough differs from its input");
  bus_data_a: assert property (TBUS_OUT == TBUF_IN)
    else $error("bus data differs from driver input");
  bus_enable_a: assert property (TBUS_OE == TBUF_EN)
    else $error("bus enable differs from driver control");
  product_gate_a: assert property (PRODUCT_OUT ==
    {CELL_IN[12] & CELL_IN[13], CELL_IN[8] & CELL_IN[9],
     CELL_IN[4] & CELL_IN[5], CELL_IN[0] & CELL_IN[1]})
    else $error("product gate output wrong");
  pair_mux_a: assert property (PAIR_OUT ==
    {PAIR_SEL[1] ? LUT_OUT[3] : LUT_OUT[2], PAIR_SEL[0] ? LUT_OUT[1] : LUT_OUT[0]})
    else $error("pair mux output wrong");
  quad_mux_a: assert property (QUAD_OUT == (QUAD_SEL ? PAIR_OUT[1] : PAIR_OUT[0]))
    else $error("quad mux output wrong");
endmodule
bind logic_tile tile_sva u_sva (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CELL_IN(CELL_IN), .FEED_IN(FEED_IN), .FEED_OUT(FEED_OUT),
  .LUT_OUT(LUT_OUT), .PRODUCT_OUT(PRODUCT_OUT), .PAIR_SEL(PAIR_SEL), .PAIR_OUT(PAIR_OUT),
  .QUAD_SEL(QUAD_SEL), .QUAD_OUT(QUAD_OUT), .TBUF_IN(TBUF_IN), .TBUF_EN(TBUF_EN),
  .TBUS_OUT(TBUS_OUT), .TBUS_OE(TBUS_OE));

// ### verification/slice_clocker.sv
// Purpose: user-logic stand-in that clocks the slices
// Assumes: slice clocks are sampled levels on CLOCK
// Notes:   a tick is 3 cycles high then 5 low, never shorter
`timescale 1ns/1ns
module slice_clocker (
  // system
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // request and slice clocks
  input  wire logic [1:0] fire,
  output logic      [1:0] slice_clk,
  output logic            busy
);
  logic [1:0] mask;  // slices being ticked
  logic [3:0] cnt;   // phase of the tick, 0 = idle
  // ============================================================
  // sequencer: levels held long enough for the two-flop sampler
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask <= 2'b00;
      cnt  <= 4'h0;
    end else if (cnt == 4'h0 && fire != 2'b00) begin
      mask <= fire;
      cnt  <= 4'h1;
    end else if (cnt != 4'h0) begin
      cnt  <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end
  // clock stands low outside a tick
  assign slice_clk = (cnt != 4'h0 && cnt < 4'h4) ? mask : 2'b00;
  assign busy      = cnt != 4'h0;
endmodule

// ### verification/tb_logic_tile.sv
// Purpose: directed bench for the logic tile
// Assumes: slice clocks come from slice_clocker
// Notes:   expectations follow from table contents written here
`timescale 1ns/1ns
module tb_logic_tile;
  logic        CLOCK, ARST_N, REG_WR, REG_RD, QUAD_SEL, QUAD_OUT, busy;
  logic [4:0]  REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA;
  logic [15:0] CELL_IN;
  logic [3:0]  DIRECT_IN, FEED_IN, LUT_OUT, STORE_OUT, SUM_OUT, PRODUCT_OUT, FEED_OUT;
  logic [1:0]  SLICE_CLK, SLICE_CE, INIT_FORCE, INVERSE_FORCE, WRITE_EN, PAIR_SEL;
  logic [1:0]  CARRY_IN, TBUF_IN, TBUF_EN, PAIR_OUT, CARRY_OUT, TBUS_OUT, TBUS_OE, fire;
  int          n_fail = 0;
  int          cmp_count = 0;
  logic_tile u_dut (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CELL_IN(CELL_IN),
    .DIRECT_IN(DIRECT_IN), .FEED_IN(FEED_IN), .SLICE_CLK(SLICE_CLK), .SLICE_CE(SLICE_CE),
    .INIT_FORCE(INIT_FORCE), .INVERSE_FORCE(INVERSE_FORCE), .WRITE_EN(WRITE_EN),
    .PAIR_SEL(PAIR_SEL), .QUAD_SEL(QUAD_SEL), .CARRY_IN(CARRY_IN), .TBUF_IN(TBUF_IN),
    .TBUF_EN(TBUF_EN), .LUT_OUT(LUT_OUT), .STORE_OUT(STORE_OUT), .SUM_OUT(SUM_OUT),
    .PRODUCT_OUT(PRODUCT_OUT), .FEED_OUT(FEED_OUT), .PAIR_OUT(PAIR_OUT),
    .QUAD_OUT(QUAD_OUT), .CARRY_OUT(CARRY_OUT), .TBUS_OUT(TBUS_OUT), .TBUS_OE(TBUS_OE));
  slice_clocker u_clk (.CLOCK(CLOCK), .ARST_N(ARST_N), .fire(fire),
                       .slice_clk(SLICE_CLK), .busy(busy));
  // ============================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLOCK);
    REG_WR    <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLOCK);
    REG_RD   <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask
  task automatic settle();
    @(posedge CLOCK);
    #1;
  endtask
  // one slice clock tick, bounded wait on the model
  task automatic tick(input logic [1:0] m);
    @(posedge CLOCK);
    fire <= m;
    @(posedge CLOCK);
    fire <= 2'b00;
    // busy rises only after this edge's updates land
    #1;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) settle();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ============================================================
  // clock and watchdog
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
  // ============================================================
  // tests
  initial begin
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD, QUAD_SEL, CELL_IN, DIRECT_IN, FEED_IN} = '0;
    {SLICE_CE, INIT_FORCE, INVERSE_FORCE, WRITE_EN, PAIR_SEL, CARRY_IN} = '0;
    {TBUF_IN, TBUF_EN, fire} = '0;
    ARST_N = 1'b0;
    repeat (4) @(posedge CLOCK);
    ARST_N <= 1'b1;
    // reset values; status and unmapped writes are ignored
    wr(5'h18, 32'hFFFF_FFFF);
    wr(5'h1C, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    $display("test reset done");
    // logic mode, carry chain and muxes
    wr(5'h00, 32'h0000_FFFF);
    wr(5'h04, 32'h0000_8000);
    @(posedge CLOCK);
    CARRY_IN <= 2'b01;
    FEED_IN  <= 4'hA;
    TBUF_IN  <= 2'b01;
    TBUF_EN  <= 2'b10;
    settle();
    chk(32'(LUT_OUT), 32'h1);
    chk(32'(SUM_OUT), 32'h2);
    chk(32'(CARRY_OUT), 32'h0);
    chk(32'(FEED_OUT), 32'hA);
    chk(32'(TBUS_OUT), 32'h1);
    chk(32'(TBUS_OE), 32'h2);
    @(posedge CLOCK);
    CELL_IN  <= 16'h00F0;
    PAIR_SEL <= 2'b01;
    QUAD_SEL <= 1'b1;
    settle();
    chk(32'(LUT_OUT), 32'h3);
    chk(32'(SUM_OUT), 32'h0);
    chk(32'(CARRY_OUT), 32'h1);
    chk(32'(PAIR_OUT), 32'h1);
    chk(32'(QUAD_OUT), 32'h0);
    chk(32'(PRODUCT_OUT), 32'h2);
    $display("test logic done");
    // flip-flop capture, then bypass input
    @(posedge CLOCK);
    SLICE_CE <= 2'b01;
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h3);
    wr(5'h10, 32'h0000_0008);
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h2);
    $display("test storage done");
    // forces, shared by both cells of the slice
    wr(5'h10, 32'h0000_0010);
    @(posedge CLOCK);
    INIT_FORCE <= 2'b01;
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h1);
    @(posedge CLOCK);
    INIT_FORCE    <= 2'b00;
    INVERSE_FORCE <= 2'b01;
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h2);
    @(posedge CLOCK);
    INVERSE_FORCE <= 2'b00;
    wr(5'h14, 32'h0000_0004);
    @(posedge CLOCK);
    INIT_FORCE <= 2'b01;
    settle();
    settle();
    chk(32'(STORE_OUT), 32'h1);
    @(posedge CLOCK);
    INIT_FORCE <= 2'b00;
    wr(5'h14, 32'h0000_0010);
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h1);
    @(posedge CLOCK);
    SLICE_CE <= 2'b00;
    tick(2'b01);
    chk(32'(STORE_OUT), 32'h3);
    $display("test forces done");
    // synchronous RAM: write entry 5 with zero
    wr(5'h14, 32'h0000_0000);
    wr(5'h10, 32'h0000_0001);
    @(posedge CLOCK);
    CELL_IN  <= 16'h0005;
    WRITE_EN <= 2'b01;
    tick(2'b01);
    chk(32'(LUT_OUT), 32'h0);
    rd(5'h00, 32'h0000_FFDF);
    $display("test ram done");
    // shift register: two enabled ticks, one disabled
    @(posedge CLOCK);
    WRITE_EN  <= 2'b00;
    DIRECT_IN <= 4'h4;
    SLICE_CE  <= 2'b10;
    wr(5'h10, 32'h0002_0000);
    tick(2'b10);
    tick(2'b10);
    @(posedge CLOCK);
    SLICE_CE <= 2'b00;
    tick(2'b10);
    rd(5'h08, 32'h0000_0003);
    $display("test shift done");
    // paired tables: 32x1 upper half, then 16x2, then dual port
    wr(5'h10, 32'h0000_0101);
    wr(5'h14, 32'h0000_0002);
    @(posedge CLOCK);
    CELL_IN   <= 16'h0003;
    DIRECT_IN <= 4'h1;
    WRITE_EN  <= 2'b01;
    tick(2'b01);
    chk(32'(PAIR_OUT[0]), 32'h1);
    rd(5'h04, 32'h0000_8008);
    rd(5'h00, 32'h0000_FFDF);
    wr(5'h14, 32'h0000_0001);
    @(posedge CLOCK);
    CELL_IN   <= 16'h0006;
    DIRECT_IN <= 4'h2;
    tick(2'b01);
    chk(32'(LUT_OUT), 32'h6);
    rd(5'h04, 32'h0000_8048);
    wr(5'h14, 32'h0000_0003);
    @(posedge CLOCK);
    CELL_IN   <= 16'h006F;
    DIRECT_IN <= 4'h0;
    tick(2'b01);
    chk(32'(LUT_OUT), 32'h6);
    rd(5'h04, 32'h0000_0048);
    $display("test pairs done");
    // latch open on inverted slice clock; cascade and and-gate generate
    wr(5'h10, 32'h0C20_0040);
    wr(5'h14, 32'h0000_0800);
    @(posedge CLOCK);
    WRITE_EN  <= 2'b00;
    CELL_IN   <= 16'h0535;
    SLICE_CE  <= 2'b10;
    DIRECT_IN <= 4'h8;
    settle();
    settle();
    chk(32'(STORE_OUT[3]), 32'h1);
    chk(32'(SUM_OUT), 32'h3);
    chk(32'(CARRY_OUT), 32'h0);
    $display("test latch done");
    close_out();
  end
endmodule
